// ---- rtl/dpsi_pkg.sv ----
// shared constants of the dual pot serial link, both ends
`default_nettype none
package dpsi_pkg;
  // pot organisation
  localparam int POTS    = 2;
  localparam int PRESETS = 4;
  localparam int WIPER_W = 6;
  localparam int TAPS    = 64;
  localparam int BYTE_W  = 8;

  // identification byte layout; the type code is arbitrary
  localparam logic [3:0] DEV_TYPE    = 4'h9;
  localparam logic [1:0] ID_ZERO     = 2'h0;
  localparam int         ID_TYPE_LSB = 4;
  localparam int         ID_ZERO_LSB = 2;
  localparam int         ID_ADDR_LSB = 0;

  // instruction byte layout
  localparam int INS_OP_LSB  = 4;
  localparam int INS_SEL_LSB = 2;
  localparam int INS_POT_BIT = 0;

  // opcodes
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_PRESET = 4'hb;
  localparam logic [3:0] OP_WR_PRESET = 4'hc;
  localparam logic [3:0] OP_RD_STATUS = 4'h5;
  localparam int         STATUS_BUSY_BIT = 0;

  // framing counters
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] LAST_BYTE = 2'h2;

  // timing
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int NV_WRITE_MS   = 10;
  localparam int NV_WRITE_CYC  = NV_WRITE_MS * CLK_MHZ * 1000;
  localparam int NV_CNT_W      = 22;
  localparam int SCK_HALF_NS   = 100;
  localparam int SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 8;
endpackage
`default_nettype wire

// ---- rtl/dpsi_if.sv ----
// serial pins between host and pot device
`default_nettype none
interface dpsi_if;
  logic sck;
  logic csN;
  logic holdN;
  logic si;
  logic soOut;
  logic soOe;
  logic soLine;

  // released line floats high through the board pull-up
  assign soLine = soOe ? soOut : 1'b1;

  modport dev (
    input  sck,
    input  csN,
    input  holdN,
    input  si,
    output soOut,
    output soOe
  );

  modport host (
    output sck,
    output csN,
    output holdN,
    output si,
    input  soLine
  );
endinterface
`default_nettype wire

// ---- rtl/dpsi_host_end.sv ----
// host end: drives the serial pins for one command at a time
`default_nettype none
module dpsi_host_end #(
  parameter int HALF_CYC = dpsi_pkg::SCK_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  dpsi_if.host            bus,
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic [3:0] cmdOp,
  input  wire logic [1:0] cmdAddr,
  input  wire logic [1:0] cmdSel,
  input  wire logic       cmdPot,
  input  wire logic [7:0] cmdData,
  input  wire logic       pauseReq,
  output logic            rspValid,
  output logic [7:0]      rspData
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LEAD  = 3'b001,
    H_SHIFT = 3'b010,
    H_TAIL  = 3'b011,
    H_GAP   = 3'b100
  } dpsi_hstate_t;

  typedef struct packed {
    dpsi_hstate_t                 st;
    logic [1:0]                   soS;
    logic [dpsi_pkg::DIV_W-1:0]   div;
    logic                         sck;
    logic                         csN;
    logic                         holdN;
    logic                         si;
    logic [2:0]                   bitCnt;
    logic [1:0]                   byteCnt;
    logic [23:0]                  tx;
    logic [7:0]                   rx;
    logic                         rsp;
    logic [7:0]                   rspData;
  } dpsi_host_t;

  dpsi_host_t s;
  dpsi_host_t next_s;
  logic       tick;
  logic [7:0] idByte;
  logic [7:0] insByte;

  // id and instruction bytes built from the command fields
  always_comb begin
    idByte  = '0;
    insByte = '0;
    idByte[dpsi_pkg::ID_TYPE_LSB +: 4]  = dpsi_pkg::DEV_TYPE;      // RL19
    idByte[dpsi_pkg::ID_ZERO_LSB +: 2]  = dpsi_pkg::ID_ZERO;
    idByte[dpsi_pkg::ID_ADDR_LSB +: 2]  = cmdAddr;
    insByte[dpsi_pkg::INS_OP_LSB +: 4]  = cmdOp;                   // RL20
    insByte[dpsi_pkg::INS_SEL_LSB +: 2] = cmdSel;
    insByte[dpsi_pkg::INS_POT_BIT]      = cmdPot;
  end

  assign tick = (s.div == dpsi_pkg::DIV_W'(HALF_CYC - 1));

  // sequencer; every byte leaves msb first
  always_comb begin
    next_s     = s;
    next_s.soS = {s.soS[0], bus.soLine};
    next_s.rsp = 1'b0;
    case (s.st)
      H_IDLE: begin
        if (cmdValid) begin
          next_s.tx      = {idByte, insByte, cmdData};             // RL4
          next_s.si      = idByte[7];
          next_s.csN     = 1'b0;                                   // RL7
          next_s.div     = '0;
          next_s.bitCnt  = '0;
          next_s.byteCnt = '0;
          next_s.st      = H_LEAD;
        end
      end
      H_LEAD: begin
        next_s.div = s.div + 1'b1;
        if (tick) begin
          next_s.div = '0;
          next_s.st  = H_SHIFT;
        end
      end
      H_SHIFT: begin
        // pause edges only ever move while the clock sits low; the half
        // period restarts so the far output settles before the next rise
        if (!s.sck && (pauseReq == s.holdN)) begin
          next_s.holdN = ~pauseReq;                                // RL9 RL10
          next_s.div   = '0;
        end else if (s.holdN) begin
          next_s.div = s.div + 1'b1;
          if (tick) begin
            next_s.div = '0;
            if (!s.sck) begin
              next_s.sck = 1'b1;
              next_s.rx  = {s.rx[6:0], s.soS[1]};
            end else begin
              next_s.sck    = 1'b0;
              next_s.tx     = {s.tx[22:0], 1'b0};
              next_s.si     = s.tx[22];
              next_s.bitCnt = s.bitCnt + 1'b1;
              if (s.bitCnt == dpsi_pkg::LAST_BIT) begin
                next_s.byteCnt = s.byteCnt + 1'b1;
                if (s.byteCnt == dpsi_pkg::LAST_BYTE) begin
                  next_s.st = H_TAIL;
                end
              end
            end
          end
        end
      end
      H_TAIL: begin
        next_s.div = s.div + 1'b1;
        if (tick) begin
          next_s.div     = '0;
          next_s.csN     = 1'b1;
          next_s.rsp     = 1'b1;
          next_s.rspData = s.rx;
          next_s.st      = H_GAP;
        end
      end
      H_GAP: begin
        // deselect time lets a preset commit start before the next frame
        next_s.div = s.div + 1'b1;
        if (tick) begin
          next_s.div = '0;
          next_s.st  = H_IDLE;
        end
      end
      default: next_s.st = H_IDLE;
    endcase
  end

  // state register; pause pin rests high when unused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.st    <= H_IDLE;
      s.csN   <= 1'b1;
      s.holdN <= 1'b1;                                             // RL11
      s.soS   <= 2'b11;
    end else begin
      s <= next_s;
    end
  end

  assign bus.sck   = s.sck;
  assign bus.csN   = s.csN;
  assign bus.holdN = s.holdN;
  assign bus.si    = s.si;
  assign cmdReady  = (s.st == H_IDLE);
  assign rspValid  = s.rsp;
  assign rspData   = s.rspData;
endmodule
`default_nettype wire

// ---- rtl/dpsi_dev_end.sv ----
// device end: serial decoder, wiper and preset registers
`default_nettype none
// Operation
// [RL1] read bits leave at serial clock fall
// [RL2] chip select high releases serial output
// [RL3] input bits sampled at serial clock rise
// [RL4] host sends opcodes, addresses, data via input
// [RL5] deselected means standby unless store runs
// [RL6] chip select low makes device active
// [RL7] nothing happens before first select fall
// [RL8] pause freezes sequence, resumes where stopped
// [RL9] host lowers pause only with clock low
// [RL10] host raises pause only with clock low
// [RL11] unused pause stays high
// [RL12] straps give two low address bits
// [RL13] strap mismatch means silence until deselect
// [RL14] at most four devices per bus
// [RL15] per pot: wiper plus four presets
// [RL16] startup copies preset zero into wiper
// [RL17] wiper picks one of 64 taps
// [RL18] wiper value drives tap switch directly
// [RL19] first byte: type, two zeros, strap address
// [RL20] second byte: opcode, preset select, pot select
// [RL21] preset stored at deselect after full write
// [RL22] busy flag readable by status command
// [RL23] select fall clears bit counter
module dpsi_dev_end #(
  parameter int NV_CYC = dpsi_pkg::NV_WRITE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  dpsi_if.dev                             bus,
  input  wire logic [1:0]                 strap,
  output logic [dpsi_pkg::POTS-1:0][dpsi_pkg::WIPER_W-1:0] wiperPos,
  output logic [dpsi_pkg::POTS-1:0][dpsi_pkg::TAPS-1:0]    tapSel,
  output logic                            standby,
  output logic                            active,
  output logic                            writeBusy
);
  localparam int W = dpsi_pkg::WIPER_W;
  localparam int P = dpsi_pkg::POTS;
  localparam int R = dpsi_pkg::PRESETS;
  localparam int B = dpsi_pkg::BYTE_W;

  typedef enum logic [1:0] {
    D_ID    = 2'b00,
    D_INSTR = 2'b01,
    D_DATA  = 2'b10,
    D_SKIP  = 2'b11
  } dpsi_dstate_t;

  typedef struct packed {
    logic [1:0]                     sckS;
    logic [1:0]                     csS;
    logic [1:0]                     holdS;
    logic [1:0]                     siS;
    logic [1:0]                     strapA;
    logic [1:0]                     strapB;
    logic                           sckQ;
    logic                           csQ;
    dpsi_dstate_t                   st;
    logic [2:0]                     bitCnt;
    logic [B-1:0]                   shIn;
    logic [3:0]                     opc;
    logic [1:0]                     sel;
    logic                           pot;
    logic [B-1:0]                   shOut;
    logic                           so;
    logic [P-1:0][W-1:0]            wiper;
    logic [P-1:0][R-1:0][W-1:0]     preset;
    logic                           pend;
    logic                           pPot;
    logic [1:0]                     pSel;
    logic [W-1:0]                   pData;
    logic                           busy;
    logic [dpsi_pkg::NV_CNT_W-1:0]  busyCnt;
    logic                           boot;
  } dpsi_dev_t;

  dpsi_dev_t    s;
  dpsi_dev_t    next_s;
  logic         sckRise;
  logic         sckFall;
  logic         csFall;
  logic         csRise;
  logic         csLow;
  logic         holdOk;
  logic         isRead;
  logic [B-1:0] inByte;
  logic [B-1:0] rdByte;
  logic [3:0]   inOp;
  logic [1:0]   inSel;
  logic         inPot;

  // edges are taken from the second sync stage and its delayed copy
  assign sckRise = s.sckS[1] & ~s.sckQ;                            // RL3
  assign sckFall = ~s.sckS[1] & s.sckQ;                            // RL1
  assign csFall  = ~s.csS[1] & s.csQ;
  assign csRise  = s.csS[1] & ~s.csQ;
  assign csLow   = ~s.csS[1];
  assign holdOk  = s.holdS[1];                                     // RL8
  assign inByte  = {s.shIn[B-2:0], s.siS[1]};
  assign inOp    = inByte[dpsi_pkg::INS_OP_LSB +: 4];              // RL20
  assign inSel   = inByte[dpsi_pkg::INS_SEL_LSB +: 2];
  assign inPot   = inByte[dpsi_pkg::INS_POT_BIT];
  assign isRead  = (s.opc == dpsi_pkg::OP_RD_WIPER) ||
                   (s.opc == dpsi_pkg::OP_RD_PRESET) ||
                   (s.opc == dpsi_pkg::OP_RD_STATUS);

  // answer byte chosen as soon as the instruction byte is complete
  always_comb begin
    rdByte = '0;
    if (inOp == dpsi_pkg::OP_RD_WIPER) begin
      rdByte[W-1:0] = s.wiper[inPot];
    end else if (inOp == dpsi_pkg::OP_RD_PRESET) begin
      rdByte[W-1:0] = s.preset[inPot][inSel];
    end else if (inOp == dpsi_pkg::OP_RD_STATUS) begin
      rdByte[dpsi_pkg::STATUS_BUSY_BIT] = s.busy;                  // RL22
    end
  end

  // next state of the whole device
  always_comb begin
    next_s        = s;
    next_s.sckS   = {s.sckS[0], bus.sck};
    next_s.csS    = {s.csS[0], bus.csN};
    next_s.holdS  = {s.holdS[0], bus.holdN};
    next_s.siS    = {s.siS[0], bus.si};
    next_s.strapA = strap;
    next_s.strapB = s.strapA;
    next_s.sckQ   = s.sckS[1];
    next_s.csQ    = s.csS[1];

    // first cycle after reset recalls preset zero into each wiper
    if (s.boot) begin
      next_s.boot = 1'b0;
      for (int p = 0; p < P; p++) begin
        next_s.wiper[p] = s.preset[p][0];                          // RL16
      end
    end

    // store timer; a running store survives deselect
    if (s.busy) begin
      next_s.busyCnt = s.busyCnt + 1'b1;
      if (s.busyCnt == dpsi_pkg::NV_CNT_W'(NV_CYC - 1)) begin
        next_s.busy    = 1'b0;                                     // RL5
        next_s.busyCnt = '0;
      end
    end

    if (csFall) begin
      next_s.st     = D_ID;                                        // RL7
      next_s.bitCnt = '0;                                          // RL23
      next_s.pend   = 1'b0;
    end else if (csRise) begin
      // a store already running drops a second commit request
      if (s.pend && !s.busy) begin
        next_s.preset[s.pPot][s.pSel] = s.pData;                   // RL21
        next_s.busy    = 1'b1;
        next_s.busyCnt = '0;
      end
      next_s.pend = 1'b0;
      next_s.st   = D_SKIP;
    end else if (csLow && holdOk && sckRise && s.st != D_SKIP) begin
      next_s.shIn   = inByte;                                      // RL3
      next_s.bitCnt = s.bitCnt + 1'b1;
      if (s.bitCnt == dpsi_pkg::LAST_BIT) begin
        case (s.st)
          D_ID: begin
            if (inByte[dpsi_pkg::ID_TYPE_LSB +: 4] == dpsi_pkg::DEV_TYPE &&
                inByte[dpsi_pkg::ID_ZERO_LSB +: 2] == dpsi_pkg::ID_ZERO &&
                inByte[dpsi_pkg::ID_ADDR_LSB +: 2] == s.strapB) begin
              next_s.st = D_INSTR;                                 // RL12 RL19
            end else begin
              next_s.st = D_SKIP;                                  // RL13
            end
          end
          D_INSTR: begin
            next_s.opc   = inOp;                                   // RL20
            next_s.sel   = inSel;
            next_s.pot   = inPot;
            next_s.shOut = rdByte;
            next_s.st    = D_DATA;
          end
          D_DATA: begin
            if (s.opc == dpsi_pkg::OP_WR_WIPER) begin
              next_s.wiper[s.pot] = inByte[W-1:0];                 // RL15
            end else if (s.opc == dpsi_pkg::OP_WR_PRESET) begin
              next_s.pend  = 1'b1;                                 // RL21
              next_s.pPot  = s.pot;
              next_s.pSel  = s.sel;
              next_s.pData = inByte[W-1:0];
            end
            next_s.st = D_SKIP;
          end
          default: next_s.st = D_SKIP;
        endcase
      end
    end else if (csLow && holdOk && sckFall && s.st == D_DATA &&
                 isRead) begin
      next_s.so    = s.shOut[B-1];                                 // RL1
      next_s.shOut = {s.shOut[B-2:0], 1'b0};
    end
  end

  // state register; select sync resets low so a held-low pin is no fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.st    <= D_SKIP;
      s.holdS <= 2'b11;
      s.boot  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // one-hot tap switch per pot, straight from the wiper register
  for (genvar p = 0; p < P; p++) begin : g_tap
    assign tapSel[p] = dpsi_pkg::TAPS'(1) << s.wiper[p];           // RL17 RL18
  end

  assign wiperPos  = s.wiper;
  assign bus.soOut = s.so;
  assign bus.soOe  = csLow && holdOk && s.st == D_DATA && isRead;  // RL2
  assign active    = csLow;                                        // RL6
  assign standby   = ~csLow && !s.busy;                            // RL5
  assign writeBusy = s.busy;
endmodule
`default_nettype wire

// ---- testbench/dpsi_properties.sv ----
// pin-level checks on the serial link between host end and device end
`default_nettype none
module dpsi_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic csN,
  input wire logic holdN,
  input wire logic si,
  input wire logic soOut,
  input wire logic soOe,
  input wire logic soLine
);
  timeunit 1ns;
  timeprecision 1ps;

  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // deselect releases the output within the two-stage sync delay
  property p_release;
    csN [*5] |-> !soOe && soLine;
  endproperty
  a_release: assert property (p_release)
    else $error("serial output driven while deselected");

  // data only moves after a clock fall, so a high phase holds it
  property p_so_steady;
    sck && $past(sck) && soOe && $past(soOe) |-> $stable(soOut);
  endproperty
  a_so_steady: assert property (p_so_steady)
    else $error("serial output moved while clock high");

  // input data must be settled across every rising edge
  property p_si_steady;
    sck |-> $stable(si);
  endproperty
  a_si_steady: assert property (p_si_steady)
    else $error("serial input moved while clock high");

  property p_hold_enter;
    $fell(holdN) |-> !sck;
  endproperty
  a_hold_enter: assert property (p_hold_enter)
    else $error("pause entered with clock high");

  property p_hold_leave;
    $rose(holdN) |-> !sck;
  endproperty
  a_hold_leave: assert property (p_hold_leave)
    else $error("pause left with clock high");

  // a pause freezes the clock and the data line
  property p_hold_freeze;
    !holdN && !$past(holdN) |-> $stable(sck) && $stable(si);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("link moved during pause");

  property p_hold_quiet;
    !holdN [*4] |-> !soOe;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("output driven during pause");

  // no clock edge outside a selection
  property p_idle_clock;
    csN |-> !sck;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("clock high while deselected");

  // a gap long enough for the device to see every fresh select fall
  property p_cs_gap;
    $rose(csN) |-> csN [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select gap too short");
endmodule
`default_nettype wire

// ---- testbench/dual_pot_serial_interface_test.sv ----
// self-checking bench joining the host end to the device end
`default_nettype none
module dual_pot_serial_interface_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 10;
  localparam int NVC  = 1000;
  localparam int LIM  = 4000;

  logic                                             clk;
  logic                                             rst_n;
  logic                                             cmdValid;
  logic                                             cmdReady;
  logic [3:0]                                       cmdOp;
  logic [1:0]                                       cmdAddr;
  logic [1:0]                                       cmdSel;
  logic                                             cmdPot;
  logic [7:0]                                       cmdData;
  logic                                             pauseReq;
  logic                                             rspValid;
  logic [7:0]                                       rspData;
  logic [1:0]                                       strap;
  logic [dpsi_pkg::POTS-1:0][dpsi_pkg::WIPER_W-1:0] wiperPos;
  logic [dpsi_pkg::POTS-1:0][dpsi_pkg::TAPS-1:0]    tapSel;
  logic                                             standby;
  logic                                             active;
  logic                                             writeBusy;
  logic [7:0]                                       rsp;
  int                                               errors;
  int                                               compares;

  dpsi_if dpsi_if_i ();

  dpsi_host_end #(.HALF_CYC(HALF)) dpsi_host_end_i (
    .clk(clk), .rst_n(rst_n), .bus(dpsi_if_i), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdSel(cmdSel), .cmdPot(cmdPot), .cmdData(cmdData),
    .pauseReq(pauseReq), .rspValid(rspValid), .rspData(rspData));

  // short store time keeps the run brief; busy still spans a frame
  dpsi_dev_end #(.NV_CYC(NVC)) dpsi_dev_end_i (
    .clk(clk), .rst_n(rst_n), .bus(dpsi_if_i), .strap(strap),
    .wiperPos(wiperPos), .tapSel(tapSel), .standby(standby),
    .active(active), .writeBusy(writeBusy));

  dpsi_properties dpsi_properties_i (
    .clk(clk), .rst_n(rst_n), .sck(dpsi_if_i.sck), .csN(dpsi_if_i.csN),
    .holdN(dpsi_if_i.holdN), .si(dpsi_if_i.si), .soOut(dpsi_if_i.soOut),
    .soOe(dpsi_if_i.soOe), .soLine(dpsi_if_i.soLine));

  // 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one whole frame; pz above zero pauses that many cycles in
  task automatic send(input logic [3:0] op, input logic [1:0] adr,
                      input logic [1:0] sel, input logic pot,
                      input logic [7:0] dat, input int pz);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < LIM);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp    <= op;
    cmdAddr  <= adr;
    cmdSel   <= sel;
    cmdPot   <= pot;
    cmdData  <= dat;
    @(posedge clk);
    cmdValid <= 1'b0;
    if (pz > 0) begin
      repeat (pz) @(posedge clk);
      pauseReq <= 1'b1;
      repeat (100) @(negedge clk);
      chk(64'({dpsi_if_i.holdN, dpsi_if_i.soOe, active}), 64'h1);
      @(posedge clk);
      pauseReq <= 1'b0;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < LIM);
    chk(64'(n < LIM), 64'h1);
    rsp = rspData;
  endtask

  // reset, then the startup state of wipers, taps and pins
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk(64'(wiperPos), 64'h0);
    chk(tapSel[0], 64'h1);
    chk(64'({standby, active, writeBusy}), 64'h4);
    chk(64'({dpsi_if_i.soOe, dpsi_if_i.soLine}), 64'h1);
    $display("test reset done");
  endtask

  // every strap value, the top tap, and a foreign address
  task automatic t_strap();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      strap <= 2'(s);
      send(dpsi_pkg::OP_WR_WIPER, 2'(s), 2'h0, 1'b0, 8'(8'h20 + s), 0);
      chk(64'(wiperPos[0]), 64'(8'h20 + s));
    end
    send(dpsi_pkg::OP_WR_WIPER, 2'h3, 2'h0, 1'b1, 8'h3f, 0);
    chk(64'(wiperPos), 64'({6'h3f, 6'h23}));
    chk(tapSel[1], 64'h1 << 63);
    chk(tapSel[0], 64'h1 << 35);
    send(dpsi_pkg::OP_WR_WIPER, 2'h1, 2'h0, 1'b1, 8'h00, 0);
    chk(64'(wiperPos[1]), 64'h3f);
    send(dpsi_pkg::OP_RD_WIPER, 2'h1, 2'h0, 1'b1, 8'h00, 0);
    chk(64'(rsp), 64'hff);
    send(dpsi_pkg::OP_RD_WIPER, 2'h3, 2'h0, 1'b1, 8'h00, 0);
    chk(64'(rsp), 64'h3f);
    $display("test strap done");
  endtask

  // pauses in the id byte and in the read byte must not lose bits
  task automatic t_pause();
    send(dpsi_pkg::OP_WR_WIPER, 2'h3, 2'h0, 1'b0, 8'h05, 60);
    chk(64'(wiperPos[0]), 64'h05);
    send(dpsi_pkg::OP_RD_WIPER, 2'h3, 2'h0, 1'b0, 8'h00, 400);
    chk(64'(rsp), 64'h05);
    $display("test pause done");
  endtask

  // preset store: busy blocks standby, status shows it, data survives,
  // and a second store while busy is dropped
  task automatic t_store();
    int n;
    send(dpsi_pkg::OP_WR_PRESET, 2'h3, 2'h2, 1'b0, 8'h2a, 0);
    repeat (6) @(negedge clk);
    chk(64'({writeBusy, standby}), 64'h2);
    send(dpsi_pkg::OP_WR_PRESET, 2'h3, 2'h3, 1'b0, 8'h15, 0);
    send(dpsi_pkg::OP_RD_STATUS, 2'h3, 2'h0, 1'b0, 8'h00, 0);
    chk(64'(rsp), 64'h01);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (writeBusy !== 1'b0 && n < LIM);
    repeat (6) @(negedge clk);
    chk(64'({writeBusy, standby}), 64'h1);
    send(dpsi_pkg::OP_RD_STATUS, 2'h3, 2'h0, 1'b0, 8'h00, 0);
    chk(64'(rsp), 64'h00);
    send(dpsi_pkg::OP_RD_PRESET, 2'h3, 2'h2, 1'b0, 8'h00, 0);
    chk(64'(rsp), 64'h2a);
    send(dpsi_pkg::OP_RD_PRESET, 2'h3, 2'h1, 1'b0, 8'h00, 0);
    chk(64'(rsp), 64'h00);
    send(dpsi_pkg::OP_RD_PRESET, 2'h3, 2'h3, 1'b0, 8'h00, 0);
    chk(64'(rsp), 64'h00);
    $display("test store done");
  endtask

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence; the last reset lands in mid-run state
  initial begin
    errors   = 0;
    compares = 0;
    rst_n    = 1'b0;
    cmdValid = 1'b0;
    cmdOp    = 4'h0;
    cmdAddr  = 2'h0;
    cmdSel   = 2'h0;
    cmdPot   = 1'b0;
    cmdData  = 8'h00;
    pauseReq = 1'b0;
    strap    = 2'h0;
    t_reset();
    t_strap();
    t_pause();
    t_store();
    t_reset();
    end_sim();
  end

  // the tests need about 9k cycles; over six times that means a hang
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
